// *** srw_pkg.sv ***
// package of constants and types for the stop recovery and watchdog block
package srw_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_WAKE_CTRL = 8'h0B;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0D;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0E;
    localparam logic [7:0] ADDR_WDOG_MODE = 8'h0F;

    // stop_wake_control fields
    localparam int WC_SRC_LO = 2;
    localparam int WC_SRC_HI = 4;
    localparam int WC_DELAY = 5;
    localparam int WC_POL = 6;
    localparam int WC_WARM = 7;
    localparam logic [2:0] WC_SRC_RESET = 3'h0;
    localparam logic WC_DELAY_RESET = 1'b1;
    localparam logic WC_POL_RESET = 1'b0;

    // wake source codes
    localparam logic [2:0] SRC_RESET_ONLY = 3'h0;
    localparam logic [2:0] SRC_RESERVED = 3'h1;
    localparam logic [2:0] SRC_P3_PIN1 = 3'h2;
    localparam logic [2:0] SRC_P3_PIN2 = 3'h3;
    localparam logic [2:0] SRC_P3_PIN3 = 3'h4;
    localparam logic [2:0] SRC_P2_PIN7 = 3'h5;
    localparam logic [2:0] SRC_NOR_LOW4 = 3'h6;
    localparam logic [2:0] SRC_NOR_ALL8 = 3'h7;

    // watchdog_mode fields
    localparam int WM_TAP_LO = 0;
    localparam int WM_TAP_HI = 1;
    localparam int WM_HALT = 2;
    localparam int WM_STOP = 3;
    localparam logic [1:0] WM_TAP_RESET = 2'h0;
    localparam logic WM_HALT_RESET = 1'b1;
    localparam logic WM_STOP_RESET = 1'b0;

    // interrupt status bits
    localparam int IRQ_WDOG = 0;
    localparam int IRQ_WAKE = 1;
    localparam int IRQ_BITS = 2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int MCLK_KHZ = 10000;
    localparam int WRITE_WINDOW_XTAL = 120;
    localparam logic [7:0] WRITE_WINDOW_CYC = 8'(WRITE_WINDOW_XTAL);
    localparam int POR_DELAY_US = 1000;
    localparam int POR_DELAY_CYC = (POR_DELAY_US * MCLK_KHZ) / 1000;
    localparam int RC_OSC_KHZ = 100;
    localparam int TMO_SEL0_MS = 5;
    localparam int TMO_SEL1_MS = 10;
    localparam int TMO_SEL2_MS = 20;
    localparam int TMO_SEL3_MS = 80;
    localparam logic [2:0] REFRESH_FLAGS = 3'h4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } srw_bus_t;

    typedef struct packed {
        logic we;
        logic [2:0] zsv;
    } srw_flags_t;

    typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_STOP} srw_state_t;

endpackage

// *** srw_top.sv ***
// stop mode recovery and watchdog reset controller
`timescale 1ns/10ps
`default_nettype none

module srw_top #(
    parameter int POR_CYC = srw_pkg::POR_DELAY_CYC,
    parameter int RC_KHZ = srw_pkg::RC_OSC_KHZ
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire srw_pkg::srw_bus_t bus,
    output logic [7:0] rdata,
    input wire logic stop_req,
    input wire logic halt_mode,
    input wire logic wdog_instr,
    input wire logic rc_osc,
    input wire logic [3:1] port3_pin,
    input wire logic [7:0] port2_pin,
    input wire logic [7:0] port2_dir_out,
    output logic core_rst_n,
    output logic stop_active,
    output srw_pkg::srw_flags_t flags_upd,
    output logic irq
);
    import srw_pkg::*;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------

    // rc ticks for a time in ms, the plain product, held to at least one tick
    function automatic logic [15:0] ms_ticks(input int ms);
        ms_ticks = 16'((ms * RC_KHZ + 0) > 0 ? ms * RC_KHZ : 1);
    endfunction

    function automatic logic [15:0] tap_limit(input logic [1:0] sel);
        case (sel)
            2'h0: tap_limit = ms_ticks(TMO_SEL0_MS);
            2'h1: tap_limit = ms_ticks(TMO_SEL1_MS);
            2'h2: tap_limit = ms_ticks(TMO_SEL2_MS);
            default: tap_limit = ms_ticks(TMO_SEL3_MS);
        endcase
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1;
    logic rst_n;

    // async assert, two-flop release
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [11:0] pin_s1;
    logic [11:0] pin_s2;
    logic rc_s3;
    logic rc_tick;
    logic [2:0] p3_sync;
    logic [7:0] p2_sync;

    // pins are asynchronous; second flop is the only reader of the first
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 12'h000;
            pin_s2 <= 12'h000;
            rc_s3 <= 1'b0;
        end else if (clk_en) begin
            pin_s1 <= {rc_osc, port3_pin, port2_pin};
            pin_s2 <= pin_s1;
            rc_s3 <= pin_s2[11];
        end
    end

    assign p2_sync = pin_s2[7:0];
    assign p3_sync = pin_s2[10:8];
    // one tick per rising edge of the watchdog oscillator
    assign rc_tick = pin_s2[11] & ~rc_s3;

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    srw_state_t state;
    logic [2:0] wake_src;
    logic wake_delay;
    logic wake_pol;
    logic warm_start;
    logic [1:0] wd_tap;
    logic wd_halt;
    logic wd_stop;
    logic [7:0] win_cnt;
    logic [31:0] hold_cnt;
    logic [15:0] wd_cnt;
    logic wd_en;
    logic [IRQ_BITS-1:0] irq_stat;
    logic [IRQ_BITS-1:0] irq_en;
    logic wake_hit;
    logic wd_fire;
    logic wd_run;
    logic win_open;
    logic wr_wc;
    logic wr_wm;
    logic wr_clr;
    logic wr_en;
    logic [7:0] p2_masked;
    logic src_level;

    assign wr_wc = bus.wr && (bus.addr == ADDR_WAKE_CTRL);
    assign wr_wm = bus.wr && (bus.addr == ADDR_WDOG_MODE);
    assign wr_clr = bus.wr && (bus.addr == ADDR_IRQ_CLEAR);
    assign wr_en = bus.wr && (bus.addr == ADDR_IRQ_ENABLE);

    // ------------------------------------------------------------
    // wake detection
    // ------------------------------------------------------------

    // output bits read as zero, the neutral input of a NOR
    assign p2_masked = p2_sync & ~port2_dir_out;

    // selected source level; codes with no pin never match below
    always_comb begin
        src_level = 1'b0;
        case (wake_src)
            SRC_P3_PIN1: src_level = p3_sync[0];
            SRC_P3_PIN2: src_level = p3_sync[1];
            SRC_P3_PIN3: src_level = p3_sync[2];
            SRC_P2_PIN7: src_level = p2_sync[7];
            SRC_NOR_LOW4: src_level = ~|p2_masked[3:0];
            SRC_NOR_ALL8: src_level = ~|p2_masked;
            default: src_level = 1'b0;
        endcase
    end

    // reserved and reset-only codes never wake; polarity picks the level
    assign wake_hit = (state == ST_STOP) && (wake_src != SRC_RESET_ONLY)
        && (wake_src != SRC_RESERVED)
        && (src_level == wake_pol);

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------

    // frozen in halt or stop unless the matching activity bit is set
    assign wd_run = wd_en && rc_tick
        && !(halt_mode && !wd_halt)
        && !((state == ST_STOP) && !wd_stop);
    assign wd_fire = wd_run && (wd_cnt >= tap_limit(wd_tap) - 16'h0001);

    // one-shot: refresh restarts, terminal count fires a core reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt <= 16'h0000;
            wd_en <= 1'b0;
        end else if (clk_en) begin
            if (wd_fire) begin
                wd_cnt <= 16'h0000;
                wd_en <= 1'b0;
            end else if (wdog_instr && state == ST_RUN) begin
                wd_cnt <= 16'h0000;
                wd_en <= 1'b1;
            end else if (wd_run) begin
                wd_cnt <= wd_cnt + 16'h0001;
            end
        end
    end

    // refresh instruction writes the zero, sign and overflow flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags_upd <= '0;
        end else if (clk_en) begin
            flags_upd.we <= wdog_instr && state == ST_RUN;
            flags_upd.zsv <= REFRESH_FLAGS;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------

    // hold: core in reset for the stabilisation count, then run
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_HOLD;
            hold_cnt <= 32'h00000000;
            core_rst_n <= 1'b0;
            stop_active <= 1'b0;
            warm_start <= 1'b0;
        end else if (clk_en) begin
            case (state)
                ST_HOLD: begin
                    if (hold_cnt >= 32'(POR_CYC) - 32'h00000001) begin
                        state <= ST_RUN;
                        core_rst_n <= 1'b1;
                    end else begin
                        hold_cnt <= hold_cnt + 32'h00000001;
                    end
                end
                ST_RUN: begin
                    if (wd_fire) begin
                        state <= ST_HOLD;
                        hold_cnt <= 32'h00000000;
                        core_rst_n <= 1'b0;
                        warm_start <= 1'b0;
                    end else if (stop_req) begin
                        state <= ST_STOP;
                        stop_active <= 1'b1;
                    end
                end
                ST_STOP: begin
                    if (wd_fire) begin
                        state <= ST_HOLD;
                        hold_cnt <= 32'h00000000;
                        core_rst_n <= 1'b0;
                        stop_active <= 1'b0;
                        warm_start <= 1'b0;
                    end else if (wake_hit) begin
                        state <= ST_HOLD;
                        core_rst_n <= 1'b0;
                        stop_active <= 1'b0;
                        warm_start <= 1'b1;
                        // fast wake: jump the count to its end
                        if (wake_delay) begin
                            hold_cnt <= 32'h00000000;
                        end else begin
                            hold_cnt <= 32'(POR_CYC);
                        end
                    end
                end
                default: begin
                    state <= ST_HOLD;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // mode write window
    // ------------------------------------------------------------

    // window restarts at every core restart, closes after the count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt <= 8'h00;
        end else if (clk_en) begin
            if (state == ST_HOLD) begin
                win_cnt <= 8'h00;
            end else if (win_open) begin
                win_cnt <= win_cnt + 8'h01;
            end
        end
    end

    assign win_open = (state == ST_RUN) && (win_cnt < WRITE_WINDOW_CYC);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------

    // wake control keeps its settings across stop recovery
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wake_src <= WC_SRC_RESET;
            wake_delay <= WC_DELAY_RESET;
            wake_pol <= WC_POL_RESET;
        end else if (clk_en && wr_wc) begin
            wake_src <= bus.wdata[WC_SRC_HI:WC_SRC_LO];
            wake_delay <= bus.wdata[WC_DELAY];
            wake_pol <= bus.wdata[WC_POL];
        end
    end

    // mode register: defaults on watchdog reset, writes only in window
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wd_tap <= WM_TAP_RESET;
            wd_halt <= WM_HALT_RESET;
            wd_stop <= WM_STOP_RESET;
        end else if (clk_en) begin
            if (wd_fire) begin
                wd_tap <= WM_TAP_RESET;
                wd_halt <= WM_HALT_RESET;
                wd_stop <= WM_STOP_RESET;
            end else if (wr_wm && win_open) begin
                wd_tap <= bus.wdata[WM_TAP_HI:WM_TAP_LO];
                wd_halt <= bus.wdata[WM_HALT];
                wd_stop <= bus.wdata[WM_STOP];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------

    // sticky events; a new event beats a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= '0;
            irq_en <= '0;
            irq <= 1'b0;
        end else if (clk_en) begin
            irq_stat[IRQ_WDOG] <= wd_fire
                | (irq_stat[IRQ_WDOG] & ~(wr_clr & bus.wdata[IRQ_WDOG]));
            irq_stat[IRQ_WAKE] <= wake_hit
                | (irq_stat[IRQ_WAKE] & ~(wr_clr & bus.wdata[IRQ_WAKE]));
            if (wr_en) begin
                irq_en <= bus.wdata[IRQ_BITS-1:0];
            end
            irq <= |(irq_stat & irq_en);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------

    // data one cycle after the strobe; mode and unmapped read zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (clk_en) begin
            rdata <= 8'h00;
            if (bus.rd) begin
                if (bus.addr == ADDR_WAKE_CTRL) begin
                    rdata <= {warm_start, wake_pol, wake_delay, wake_src,
                        2'b00};
                end else if (bus.addr == ADDR_IRQ_STATUS) begin
                    rdata <= 8'({irq_stat});
                end else if (bus.addr == ADDR_IRQ_ENABLE) begin
                    rdata <= 8'({irq_en});
                end else if (bus.addr == ADDR_WDOG_MODE) begin
                    rdata <= 8'h00;
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** srw_core_model.sv ***
// model of the cpu core and wake pins beside the recovery block
`timescale 1ns/10ps
`default_nettype none
module srw_core_model #(
    parameter int RC_HALF_NS = 515
) (
    input wire logic mclk,
    output logic stop_req,
    output logic halt_mode,
    output logic wdog_instr,
    output logic rc_osc,
    output logic [3:1] port3_pin,
    output logic [7:0] port2_pin,
    output logic [7:0] port2_dir_out
);
    // ------------------------------------------------------------
    // core pulses, pin levels and the rc oscillator
    // ------------------------------------------------------------
    // idle levels at time zero
    initial begin
        stop_req = 1'b0;
        halt_mode = 1'b0;
        wdog_instr = 1'b0;
        rc_osc = 1'b0;
        port3_pin = 3'h0;
        port2_pin = 8'h00;
        port2_dir_out = 8'h00;
    end
    // free running, phase unrelated to mclk
    always #RC_HALF_NS rc_osc = ~rc_osc;
    // refresh instruction, one cycle, issued when the bench says
    task automatic pulse_refresh();
        @(posedge mclk);
        wdog_instr <= 1'b1;
        @(posedge mclk);
        wdog_instr <= 1'b0;
    endtask
    task automatic pulse_stop();
        @(posedge mclk);
        stop_req <= 1'b1;
        @(posedge mclk);
        stop_req <= 1'b0;
    endtask
    task automatic set_halt(input logic h);
        @(posedge mclk);
        halt_mode <= h;
    endtask
    // levels hold until changed, at least three cycles, past the two-flop sync
    task automatic set_pins(input logic [10:0] p, input logic [7:0] dir);
        @(posedge mclk);
        port3_pin <= p[10:8];
        port2_pin <= p[7:0];
        port2_dir_out <= dir;
    endtask
endmodule
`default_nettype wire

// *** srw_top_asserts.sv ***
// port checks for the stop recovery and watchdog block
`timescale 1ns/10ps
`default_nettype none
module srw_top_asserts
    import srw_pkg::*;
#(
    parameter int POR_CYC = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire srw_pkg::srw_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic stop_req,
    input wire logic wdog_instr,
    input wire logic core_rst_n,
    input wire logic stop_active,
    input wire srw_pkg::srw_flags_t flags_upd
);
    // ------------------------------------------------------------
    // helpers and assertions
    // ------------------------------------------------------------
    localparam int HOLD_MAX = POR_CYC + 8;
    int lowcnt;
    logic warm;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // cycles the core has been held; slack covers reset sync
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lowcnt <= 0;
        end else if (core_rst_n) begin
            lowcnt <= 0;
        end else if (clk_en) begin
            lowcnt <= lowcnt + 1;
        end
    end
    // expected start type, lags one edge so reads must come later
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            warm <= 1'b0;
        end else if ($fell(stop_active)) begin
            warm <= 1'b1;
        end else if ($fell(core_rst_n)) begin
            warm <= 1'b0;
        end
    end
    sequence s_refresh;
        wdog_instr && clk_en && core_rst_n && !stop_active;
    endsequence
    sequence s_flag_pulse;
        flags_upd.we && flags_upd.zsv == REFRESH_FLAGS;
    endsequence
    chk_flag_update: assert property (s_refresh |=> s_flag_pulse)
        else $error("refresh left flags alone");
    chk_flag_cause: assert property (
        flags_upd.we |-> $past(wdog_instr))
        else $error("flag update without refresh");
    chk_refresh_held: assert property (
        wdog_instr && !core_rst_n |=> !flags_upd.we)
        else $error("refresh taken while core held");
    chk_mode_hidden: assert property (
        bus.rd && bus.addr == ADDR_WDOG_MODE |=> rdata == 8'h00)
        else $error("watchdog mode read back");
    chk_stop_enter: assert property (
        stop_req && clk_en && core_rst_n && !stop_active |=> stop_active)
        else $error("stop request not taken");
    chk_wake_resets: assert property (
        $fell(stop_active) |-> !core_rst_n)
        else $error("stop exit without core reset");
    chk_hold_bound: assert property (lowcnt <= HOLD_MAX)
        else $error("core held too long");
    chk_warm_read: assert property (
        bus.rd && clk_en && bus.addr == ADDR_WAKE_CTRL
        |=> rdata[WC_WARM] == warm)
        else $error("start type bit wrong");
endmodule
bind srw_top srw_top_asserts #(.POR_CYC(POR_CYC)) i_chk (
    .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .bus(bus),
    .rdata(rdata), .stop_req(stop_req), .wdog_instr(wdog_instr),
    .core_rst_n(core_rst_n), .stop_active(stop_active),
    .flags_upd(flags_upd)
);
`default_nettype wire

// *** tb_stop_recovery_watchdog.sv ***
// self-checking bench for the stop recovery and watchdog block
`timescale 1ns/10ps
`default_nettype none
module tb_stop_recovery_watchdog;
    import srw_pkg::*;
    // ------------------------------------------------------------
    // bench
    // ------------------------------------------------------------
    localparam int POR_T = 8;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic en = 1'b1;
    srw_bus_t bus = '0;
    logic stop_req, halt_mode, wdog_instr, rc_osc;
    logic core_rst_n, stop_active, irq, pol, dly;
    logic [3:1] p3;
    logic [7:0] p2, p2dir, rdata;
    srw_flags_t flags;
    int miscompares = 0;
    int checked = 0;
    int lim[4] = '{TMO_SEL0_MS, TMO_SEL1_MS, TMO_SEL2_MS, TMO_SEL3_MS};
    int k, n;
    always #50 mclk = ~mclk;
    // rc rate 1 khz makes each tap limit its value in ticks
    srw_top #(.POR_CYC(POR_T), .RC_KHZ(1)) i_dut (
        .mclk(mclk), .nrst(nrst), .clk_en(en), .bus(bus),
        .rdata(rdata), .stop_req(stop_req), .halt_mode(halt_mode),
        .wdog_instr(wdog_instr), .rc_osc(rc_osc), .port3_pin(p3),
        .port2_pin(p2), .port2_dir_out(p2dir), .core_rst_n(core_rst_n),
        .stop_active(stop_active), .flags_upd(flags), .irq(irq));
    srw_core_model i_core (
        .mclk(mclk), .stop_req(stop_req), .halt_mode(halt_mode),
        .wdog_instr(wdog_instr), .rc_osc(rc_osc), .port3_pin(p3),
        .port2_pin(p2), .port2_dir_out(p2dir));
    // pin pattern giving every source the level v; port 2 bit 0 and 1
    // are driven high as outputs to prove they stay out of the nor
    function automatic logic [10:0] pat(input logic v);
        return v ? {3'h7, 8'h83} : {3'h0, 8'h7C};
    endfunction
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic cmp(input string s, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    // data stands only in the cycle after the read edge
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input string s);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        cmp(s, e, rdata);
    endtask
    task automatic wait_run();
        for (int i = 0; i < 100 && core_rst_n !== 1'b1; i++) tick();
        cmp("run", 8'h01, 8'(core_rst_n));
    endtask
    // count rc ticks until the core reset falls
    task automatic wd_fire(input int l, input string s);
        int t;
        logic rp;
        t = 0;
        rp = rc_osc;
        for (int i = 0; i < 4000 && core_rst_n === 1'b1; i++) begin
            tick();
            t += int'(rc_osc && !rp);
            rp = rc_osc;
        end
        cmp(s, 8'h01, 8'(t >= l - 1 && t <= l + 1));
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
    endtask
    task automatic print_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard, several times the expected run
    initial begin
        #3000000;
        miscompares++;
        print_verdict();
    end
    // main sequence
    initial begin
        do_reset();
        wait_run();
        rd(ADDR_WAKE_CTRL, 8'h20, "wake_rst");
        rd(ADDR_WDOG_MODE, 8'h00, "mode_rd");
        rd(8'h10, 8'h00, "unmapped");
        rd(ADDR_IRQ_STATUS, 8'h00, "status_rst");
        // a write while the clock enable is low must leave no trace
        @(posedge mclk);
        en <= 1'b0;
        wr(ADDR_WAKE_CTRL, 8'h40);
        en <= 1'b1;
        rd(ADDR_WAKE_CTRL, 8'h20, "frozen");
        $display("test reset done");
        for (int t = 0; t < 4; t++) begin
            wait_run();
            wr(ADDR_IRQ_ENABLE, 8'h03);
            wr(ADDR_WDOG_MODE, 8'h04 | 8'(t));
            i_core.pulse_refresh();
            wd_fire(lim[t], "wd_tap");
            i_core.pulse_refresh();
            cmp("irq_wd", 8'h01, 8'(irq));
            wait_run();
            rd(ADDR_IRQ_STATUS, 8'h01, "status_wd");
            rd(ADDR_WAKE_CTRL, 8'h20, "cold_wd");
            wr(ADDR_IRQ_CLEAR, 8'h01);
            rd(ADDR_IRQ_STATUS, 8'h00, "status_clr");
            cmp("irq_clr", 8'h00, 8'(irq));
        end
        $display("test taps done");
        wait_run();
        repeat (1000) tick();
        cmp("wd_idle", 8'h01, 8'(core_rst_n));
        wr(ADDR_WDOG_MODE, 8'h07);
        i_core.pulse_refresh();
        i_core.set_halt(1'b1);
        wd_fire(lim[0], "wd_lock");
        i_core.set_halt(1'b0);
        wait_run();
        wr(ADDR_WDOG_MODE, 8'h00);
        i_core.pulse_refresh();
        i_core.set_halt(1'b1);
        repeat (300) tick();
        cmp("wd_halt", 8'h01, 8'(core_rst_n));
        i_core.set_halt(1'b0);
        wd_fire(lim[0], "wd_resume");
        $display("test lock_halt done");
        wait_run();
        wr(ADDR_IRQ_CLEAR, 8'h03);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        for (int s = 2; s < 8; s++) begin
            pol = s[0];
            dly = (s == 2);
            wait_run();
            wr(ADDR_WAKE_CTRL, {1'b0, pol, dly, 3'(s), 2'b00});
            i_core.set_pins(pat(~pol), (s == 7) ? 8'h83 : 8'h03);
            i_core.pulse_stop();
            repeat (8) tick();
            cmp("no_early", 8'h01, 8'(stop_active));
            i_core.set_pins(pat(pol), (s == 7) ? 8'h83 : 8'h03);
            for (k = 0; k < 50 && core_rst_n === 1'b1; k++) tick();
            for (n = 0; n < 50 && core_rst_n === 1'b0; n++) tick();
            cmp("wake_hold", 8'h01,
                8'(dly ? (n >= POR_T && n <= POR_T + 2) : (n <= 2)));
            wait_run();
            rd(ADDR_WAKE_CTRL, {2'b11, dly, 3'(s), 2'b00} ^
               {1'b0, ~pol, 6'h00}, "warm");
            rd(ADDR_IRQ_STATUS, 8'h02, "status_wake");
            cmp("irq_mask", 8'h00, 8'(irq));
            wr(ADDR_IRQ_CLEAR, 8'h02);
        end
        $display("test wake done");
        for (int s = 0; s < 2; s++) begin
            wait_run();
            wr(ADDR_WAKE_CTRL, {3'h3, 3'(s), 2'b00});
            i_core.set_pins(pat(1'b0), 8'h00);
            i_core.pulse_stop();
            i_core.set_pins(pat(1'b1), 8'h00);
            repeat (20) tick();
            cmp("no_wake", 8'h01, 8'(stop_active));
            do_reset();
            wait_run();
            rd(ADDR_WAKE_CTRL, 8'h20, "cold");
        end
        $display("test reserved done");
        print_verdict();
    end
endmodule
`default_nettype wire
